// >>> lookup_engine_ctrl_irq.v
// lookup engine forwarding control, aging period and table event registers
`timescale 1ns/1ps
`include "lookup_engine_map.vh"
module lookup_engine_ctrl_irq #(
  parameter PORTS         = 7,
  parameter AGE_CNT_W     = 3,
  parameter SECOND_CYCLES = `LE_SECOND_CYCLES
) (
  input  wire                 clock,
  input  wire                 rst_n,
  input  wire [15:0]          reg_addr,
  input  wire                 reg_write,
  input  wire                 reg_read,
  input  wire [7:0]           reg_wdata,
  output reg  [7:0]           reg_rdata,
  input  wire                 pkt_valid,
  input  wire                 double_tag_mode,
  input  wire                 reserved_mcast,
  input  wire                 hit_dynamic,
  input  wire                 hit_static,
  input  wire [PORTS-1:0]     addr_port_map,
  input  wire [PORTS-1:0]     vlan_port_map,
  input  wire [PORTS-1:0]     host_port_map,
  input  wire [2:0]           da_priority,
  input  wire [2:0]           sa_priority,
  output reg                  fwd_valid,
  output reg  [PORTS-1:0]     fwd_port_map,
  output reg  [2:0]           address_based_priority,
  input  wire                 flush_trigger,
  output reg                  flush_active,
  output reg                  flush_dynamic,
  output reg                  flush_static,
  input  wire [AGE_CNT_W-1:0] entry_age_count,
  input  wire                 age_start,
  output reg                  age_expired,
  input  wire                 learn_fail_event,
  input  wire                 almost_full_event,
  input  wire                 write_fail_event,
  output reg                  lookup_engine_event,
  output reg                  lookup_engine_irq
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0]  fwd_ctrl;
  reg  [7:0]  aging;
  reg  [2:0]  evt_status;
  reg  [2:0]  evt_mask;
  wire [2:0]  next_status;
  wire [2:0]  mask_now;
  wire [2:0]  irq_bits;
  reg  [7:0]  next_rdata;
  reg  [31:0] age_left;
  wire        sec_tick;
  wire        wr_fwd    = reg_write && reg_addr == `LE_OFS_FWD_CTRL;
  wire        wr_aging  = reg_write && reg_addr == `LE_OFS_AGING;
  wire        wr_status = reg_write && reg_addr == `LE_OFS_EVT_STATUS;
  wire        wr_mask   = reg_write && reg_addr == `LE_OFS_EVT_MASK;
  wire [1:0]  flush_opt = fwd_ctrl[`LE_FLD_FLUSH_HI:`LE_FLD_FLUSH_LO];
  wire [1:0]  prio_sel  = fwd_ctrl[`LE_FLD_PRIO_HI:`LE_FLD_PRIO_LO];
  wire [2:0]  events    = {learn_fail_event, almost_full_event, write_fail_event};
  genvar      g;

  // one-cycle enable pulse per second; the aging countdown runs on it, while a start reloads the timer on any cycle

  second_tick #(
    .CYCLES (SECOND_CYCLES)
  ) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (sec_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped offsets and the unused upper bits of status and mask read as zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `LE_OFS_FWD_CTRL:   next_rdata = fwd_ctrl;
      `LE_OFS_AGING:      next_rdata = aging;
      `LE_OFS_EVT_STATUS: next_rdata = {5'h00, evt_status};
      `LE_OFS_EVT_MASK:   next_rdata = {5'h00, evt_mask};
      default:            next_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and read path
  // bit 7 of the forwarding control byte is kept as plain storage
  // read data is registered and stands until the next read strobe
  always @(posedge clock) begin
    if (!rst_n) begin
      fwd_ctrl  <= `LE_RST_FWD_CTRL;
      aging     <= `LE_RST_AGING;
      evt_mask  <= `LE_RST_EVT_MASK;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_fwd)
        fwd_ctrl <= reg_wdata;
      if (wr_aging)
        aging <= reg_wdata;
      if (wr_mask)
        evt_mask <= reg_wdata[2:0];
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status, one flag per table event: writing 1 clears it
  // an event in the same cycle as the clear wins, so no event is lost
  // a mask being written takes effect on the request at the same edge
  assign mask_now = wr_mask ? reg_wdata[2:0] : evt_mask;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_evt
      // set by hardware, cleared only by a software write of 1
      assign next_status[g] = events[g] |
                              (evt_status[g] & ~(wr_status & reg_wdata[g]));
      // an unmasked flag requests an interrupt
      assign irq_bits[g]    = next_status[g] & ~mask_now[g];
    end
  endgenerate

  // status, global event and request are all registered outputs

  always @(posedge clock) begin
    if (!rst_n) begin
      evt_status          <= 3'h0;
      lookup_engine_event <= 1'b0;
      lookup_engine_irq   <= 1'b0;
    end else begin
      evt_status          <= next_status;
      lookup_engine_event <= |next_status;
      lookup_engine_irq   <= |irq_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forwarding decision
  // the multicast trap outranks egress filtering; map and priority
  // hold their last value between lookup results
  always @(posedge clock) begin
    if (!rst_n) begin
      fwd_valid              <= 1'b0;
      fwd_port_map           <= {PORTS{1'b0}};
      address_based_priority <= 3'h0;
    end else begin
      fwd_valid <= pkt_valid;
      if (pkt_valid) begin
        if (fwd_ctrl[`LE_BIT_MC_TRAP] && double_tag_mode && reserved_mcast)
          fwd_port_map <= host_port_map;
        else if (hit_dynamic && fwd_ctrl[`LE_BIT_DYN_VFILT])
          fwd_port_map <= addr_port_map & vlan_port_map;
        else if (hit_static && fwd_ctrl[`LE_BIT_STA_VFILT])
          fwd_port_map <= addr_port_map & vlan_port_map;
        else
          fwd_port_map <= addr_port_map;
        case (prio_sel)
          `LE_PRIO_DA:   address_based_priority <= da_priority;
          `LE_PRIO_SA:   address_based_priority <= sa_priority;
          `LE_PRIO_HIGH: address_based_priority <= (da_priority > sa_priority) ?
                                                   da_priority : sa_priority;
          default:       address_based_priority <= (da_priority < sa_priority) ?
                                                   da_priority : sa_priority;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flush scope, trigger is a single-cycle request
  // the trigger register itself lives outside, so self-clearing is its job;
  // here the outputs are one-cycle pulses and option none gives no pulse
  always @(posedge clock) begin
    if (!rst_n) begin
      flush_active  <= 1'b0;
      flush_dynamic <= 1'b0;
      flush_static  <= 1'b0;
    end else begin
      flush_active  <= flush_trigger && flush_opt != `LE_FLUSH_NONE;
      flush_dynamic <= flush_trigger && flush_opt[0];
      flush_static  <= flush_trigger && flush_opt[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aging timer: period times entry age count, in seconds
  // a new start reloads the timer; a zero product never expires
  // the first second may be short, as the tick runs free from reset
  always @(posedge clock) begin
    if (!rst_n) begin
      age_left    <= 32'h0;
      age_expired <= 1'b0;
    end else begin
      age_expired <= 1'b0;
      if (age_start)
        age_left <= {21'h0, aging * {8'h00, entry_age_count}};
      else if (sec_tick && age_left != 32'h0) begin
        age_left <= age_left - 32'h1;
        if (age_left == 32'h1)
          age_expired <= 1'b1;
      end
    end
  end
endmodule

// >>> lookup_engine_ctrl_irq_chk.sv
// port assertions for the lookup engine control block
`timescale 1ns/1ps
module lookup_engine_ctrl_irq_chk #(
  parameter PORTS = 7
) (
  input wire             clock,
  input wire             rst_n,
  input wire             reg_write,
  input wire             pkt_valid,
  input wire [2:0]       da_priority,
  input wire [2:0]       sa_priority,
  input wire             fwd_valid,
  input wire [PORTS-1:0] fwd_port_map,
  input wire [2:0]       address_based_priority,
  input wire             flush_trigger,
  input wire             flush_active,
  input wire             flush_dynamic,
  input wire             flush_static,
  input wire             learn_fail_event,
  input wire             almost_full_event,
  input wire             write_fail_event,
  input wire             lookup_engine_event,
  input wire             lookup_engine_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  fwd_pulse_a: assert property (##1 fwd_valid == $past(pkt_valid)) else $error("fwd pulse");
  prio_pick_a: assert property (pkt_valid |=> address_based_priority == $past(da_priority) ||
    address_based_priority == $past(sa_priority)) else $error("prio source");
  map_hold_a: assert property (!pkt_valid |=> $stable(fwd_port_map) &&
    $stable(address_based_priority)) else $error("map hold");
  flush_kind_a: assert property (flush_dynamic || flush_static |-> flush_active &&
    $past(flush_trigger)) else $error("flush kind");
  flush_idle_a: assert property (!flush_trigger |=> !flush_active) else $error("flush");
  event_set_a: assert property (learn_fail_event || almost_full_event || write_fail_event
    |=> lookup_engine_event) else $error("event set");
  irq_event_a: assert property (lookup_engine_irq |-> lookup_engine_event) else $error("irq");
  event_idle_a: assert property (!(learn_fail_event || almost_full_event || write_fail_event ||
    reg_write || lookup_engine_event) |=> !lookup_engine_event) else $error("idle");
endmodule

// >>> lookup_engine_ctrl_irq_tb.sv
// self-checking bench for the lookup engine control block
`timescale 1ns/1ps
bind lookup_engine_ctrl_irq lookup_engine_ctrl_irq_chk #(.PORTS(PORTS)) chk (.*);
module lookup_engine_ctrl_irq_tb;
  reg        clock, rst_n, wr, rd, pv, dt, rm, hd, hs, ft, as, lf, af, wf;
  reg [15:0] addr;
  reg [7:0]  wd;
  reg [6:0]  am, vm, hm;
  reg [2:0]  dp, sp, ac;
  wire [7:0] rdat;
  wire [6:0] fm;
  wire [2:0] pr;
  wire       fv, fa, fd, fs, ax, ev, irq;
  integer    fail_count, n_compared, i, n;
  lookup_engine_ctrl_irq #(.SECOND_CYCLES(10)) uut (.clock(clock), .rst_n(rst_n),
    .reg_addr(addr), .reg_write(wr), .reg_read(rd), .reg_wdata(wd), .reg_rdata(rdat),
    .pkt_valid(pv), .double_tag_mode(dt), .reserved_mcast(rm), .hit_dynamic(hd),
    .hit_static(hs), .addr_port_map(am), .vlan_port_map(vm), .host_port_map(hm),
    .da_priority(dp), .sa_priority(sp), .fwd_valid(fv), .fwd_port_map(fm),
    .address_based_priority(pr), .flush_trigger(ft), .flush_active(fa),
    .flush_dynamic(fd), .flush_static(fs), .entry_age_count(ac), .age_start(as),
    .age_expired(ax), .learn_fail_event(lf), .almost_full_event(af),
    .write_fail_event(wf), .lookup_engine_event(ev), .lookup_engine_irq(irq));
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  task give_verdict; begin
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  task chk(input [39:0] nm, input [7:0] e, input [7:0] g); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  end endtask
  task w(input [15:0] a, input [7:0] d); begin
    @(negedge clock) {addr, wd, wr} = {a, d, 1'b1};
    @(negedge clock) wr = 0;
  end endtask
  task r(input [15:0] a, input [7:0] e); begin
    @(negedge clock) {addr, rd} = {a, 1'b1};
    @(negedge clock) rd = 0;
    chk("reg", e, rdat);
  end endtask
  task p(input [3:0] f, input [6:0] em, input [2:0] ep); begin
    @(negedge clock) {dt, rm, hd, hs, pv} = {f, 1'b1};
    @(negedge clock) pv = 0;
    chk("fwd", 1, fv);
    chk("map", em, fm);
    chk("prio", ep, pr);
  end endtask
  task ep(input [2:0] e); begin
    @(negedge clock) {lf, af, wf} = e;
    @(negedge clock) {lf, af, wf} = 0;
    @(negedge clock) chk("evt", 1, ev);
  end endtask
  initial begin
    #(25 * 4000) fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    {wr, rd, pv, dt, rm, hd, hs, ft, as, lf, af, wf, addr, wd} = 0;
    {am, vm, hm, dp, sp, ac} = {7'h5b, 7'h36, 7'h40, 3'h5, 3'h2, 3'h3};
    {fail_count, n_compared, rst_n} = 0;
    repeat (6) @(negedge clock);
    rst_n = 1;
    r(16'h0312, 8'h00);
    r(16'h0313, 8'h4b);
    r(16'h0314, 8'h00);
    r(16'h0315, 8'h07);
    r(16'h0316, 8'h00);
    p(4'b1110, 7'h5b, 5);
    w(16'h0312, 8'h20);
    p(4'b0010, 7'h12, 5);
    p(4'b0001, 7'h5b, 5);
    w(16'h0312, 8'h50);
    r(16'h0312, 8'h50);
    p(4'b1110, 7'h40, 5);
    p(4'b0110, 7'h5b, 5);
    p(4'b0001, 7'h12, 5);
    for (i = 0; i < 4; i = i + 1) begin
      w(16'h0312, i);
      p(4'b0010, 7'h5b, i[0] ? 3'h2 : 3'h5);
      w(16'h0312, i << 2);
      @(negedge clock) ft = 1;
      @(negedge clock) ft = 0;
      chk("flush", {i != 0, i[1], i[0]}, {fa, fs, fd});
    end
    w(16'h0313, 8'h02);
    @(negedge clock) as = 1;
    @(negedge clock) as = 0;
    for (n = 0; !ax && n < 200; n = n + 1) @(negedge clock);
    chk("age", 1, n > 44 && n < 66);
    w(16'h0315, 8'h00);
    ep(3'h4);
    chk("irq", 1, irq);
    r(16'h0314, 8'h04);
    w(16'h0315, 8'h04);
    chk("irq", 0, irq);
    w(16'h0314, 8'h04);
    r(16'h0314, 8'h00);
    chk("evt", 0, ev);
    ep(3'h3);
    chk("irq", 1, irq);
    r(16'h0314, 8'h03);
    w(16'h0314, 8'h01);
    r(16'h0314, 8'h02);
    w(16'h0314, 8'h02);
    r(16'h0314, 8'h00);
    give_verdict;
  end
endmodule

// >>> lookup_engine_map.vh
// register offsets, field positions, reset values and timing counts of the lookup engine control block
`ifndef LOOKUP_ENGINE_MAP_VH
`define LOOKUP_ENGINE_MAP_VH
`define LE_ADDR_W           16
`define LE_OFS_FWD_CTRL     16'h0312
`define LE_OFS_AGING        16'h0313
`define LE_OFS_EVT_STATUS   16'h0314
`define LE_OFS_EVT_MASK     16'h0315
`define LE_BIT_MC_TRAP      6
`define LE_BIT_DYN_VFILT    5
`define LE_BIT_STA_VFILT    4
`define LE_FLD_FLUSH_HI     3
`define LE_FLD_FLUSH_LO     2
`define LE_FLD_PRIO_HI      1
`define LE_FLD_PRIO_LO      0
`define LE_BIT_LEARN_FAIL   2
`define LE_BIT_ALMOST_FULL  1
`define LE_BIT_WRITE_FAIL   0
`define LE_RST_FWD_CTRL     8'h00
`define LE_RST_AGING        8'h4b
`define LE_RST_EVT_MASK     3'h7
`define LE_FLUSH_NONE       2'h0
`define LE_FLUSH_DYN        2'h1
`define LE_FLUSH_STA        2'h2
`define LE_FLUSH_BOTH       2'h3
`define LE_PRIO_DA          2'h0
`define LE_PRIO_SA          2'h1
`define LE_PRIO_HIGH        2'h2
`define LE_PRIO_LOW         2'h3
`define LE_CLOCK_HZ         40000000
`define LE_SECOND_CYCLES    (`LE_CLOCK_HZ)
`endif

// >>> second_tick.v
// divider giving a one-cycle pulse once per second of core clock
`timescale 1ns/1ps
module second_tick #(
  parameter CYCLES = 40000000
) (
  input  wire clock,
  input  wire rst_n,
  output reg  tick
);
  reg [31:0] count;

  always @(posedge clock) begin
    if (!rst_n) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count >= CYCLES - 1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
